// ### shared/crcg_pkg.sv
/*
  Constants for the CRC generator control block: register indices, field positions, reset values,
  FIFO depth decode and shift rate. Assumes a 16-bit register port addressed by word index.
*/
// How it works
// - With stop-when-idle set, all shifting and FIFO draining halt while idle is asserted.
// - With interrupt source select one, interrupt fires when the valid word count goes 1 to 0.
// - With interrupt source select zero, interrupt fires when shifting completes, result valid.
// - Valid word count is a read-only five-bit field of control register one.
// - Module enable low empties FIFO, zeroes count, resets engine, data and result.
// - Hardware clears shift start when done; a software clear raises no interrupt.
// - Words shift MSb first by default, LSb first when lsb select set; result not reflected.
// - FIFO depth is 4, 8 or 16 by data width; full when count reaches depth.
package crcg_pkg;
  // Register indices
  localparam logic [3:0] A_CTL1 = 4'h0;
  localparam logic [3:0] A_CTL2 = 4'h1;
  localparam logic [3:0] A_XORL = 4'h2;
  localparam logic [3:0] A_XORH = 4'h3;
  localparam logic [3:0] A_DATL = 4'h4;
  localparam logic [3:0] A_DATH = 4'h5;
  localparam logic [3:0] A_RESL = 4'h6;
  localparam logic [3:0] A_RESH = 4'h7;
  localparam logic [3:0] A_ISTAT = 4'h8;
  localparam logic [3:0] A_IMASK = 4'h9;
  // Control register one field positions
  localparam int B_EN = 15;
  localparam int B_SIDL = 13;
  localparam int B_CNT = 8;
  localparam int B_FULL = 7;
  localparam int B_EMPTY = 6;
  localparam int B_ISEL = 5;
  localparam int B_GO = 4;
  localparam int B_LSB = 3;
  // Control register two field positions
  localparam int B_DW = 8;
  localparam int B_POLYNOMIAL_LENGTH = 0;
  // Reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // FIFO depths and data width thresholds
  localparam logic [4:0] DEPTH_WIDE = 5'h04;
  localparam logic [4:0] DEPTH_MID = 5'h08;
  localparam logic [4:0] DEPTH_NARROW = 5'h10;
  localparam logic [4:0] DW_WIDE_MIN = 5'h10;
  localparam logic [4:0] DW_MID_MIN = 5'h08;
  // Engine shift rate, bits per clock
  localparam logic [5:0] BITS_PER_CYC = 6'h02;

  // FIFO depth for a data width setting
  function automatic logic [4:0] crcg_depth(input logic [4:0] dw);
    if (dw >= DW_WIDE_MIN)
      return DEPTH_WIDE;
    else if (dw >= DW_MID_MIN)
      return DEPTH_MID;
    else
      return DEPTH_NARROW;
  endfunction
endpackage

// ### design/crcg_engine.sv
/*
  CRC shift engine: holds one word and the running CRC, shifts two bits per clock.
  Assumes the caller loads only while idle and keeps polynomial settings stable while busy.
*/
`timescale 1ns/100ps
module crcg_engine
  import crcg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  // Word load and shift control
  input wire logic load,
  input wire logic [31:0] word,
  input wire logic shift_en,
  // Configuration
  input wire logic [4:0] dw,
  input wire logic lsb,
  input wire logic [31:0] poly,
  input wire logic [4:0] polynomial_length,
  // Result write from software
  input wire logic res_wr_lo,
  input wire logic res_wr_hi,
  input wire logic [15:0] res_wdata,
  // Status
  output logic idle,
  output logic [31:0] crc
);
  logic [31:0] sh_ff;
  logic [31:0] crc_ff;
  logic [5:0] left_ff;
  logic [31:0] c1;
  logic [31:0] c2;

  // One serial step of a normal CRC of length n+1; x0 always taps
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d,
                                           input logic [31:0] p, input logic [4:0] n);
    logic fb;
    logic [31:0] mask;
    fb = c[n] ^ d;
    mask = 32'hFFFF_FFFF >> (5'd31 - n);
    return ({c[30:0], 1'b0} ^ ({32{fb}} & (p | 32'h0000_0001))) & mask;
  endfunction

  // Two steps per clock, data bit taken from the selected end
  always_comb
  begin
    c1 = crc_step(crc_ff, lsb ? sh_ff[0] : sh_ff[31], poly, polynomial_length);
    c2 = crc_step(c1, lsb ? sh_ff[1] : sh_ff[30], poly, polynomial_length);
  end

  // Word buffer, bit counter and CRC register
  always_ff @(posedge mclk)
  begin
    if (rst || clr)
    begin
      sh_ff <= RST_WORD;
      crc_ff <= RST_WORD;
      left_ff <= 6'h00;
    end
    else
    begin
      if (load)
      begin
        sh_ff <= lsb ? word : word << (5'd31 - dw);
        left_ff <= {1'b0, dw} + 6'h01;
      end
      else if (shift_en && left_ff != 6'h00)
      begin
        if (left_ff >= BITS_PER_CYC)
        begin
          crc_ff <= c2;
          sh_ff <= lsb ? sh_ff >> 2 : sh_ff << 2;
          left_ff <= left_ff - BITS_PER_CYC;
        end
        else
        begin
          crc_ff <= c1;
          sh_ff <= lsb ? sh_ff >> 1 : sh_ff << 1;
          left_ff <= 6'h00;
        end
      end
      // Software preload of the result wins over a shift
      if (res_wr_lo)
        crc_ff[15:0] <= res_wdata;
      if (res_wr_hi)
        crc_ff[31:16] <= res_wdata;
    end
  end

  assign idle = left_ff == 6'h00;
  assign crc = crc_ff;

  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || clr);
  property p_load_align;
    load |=> (lsb ? sh_ff == $past(word) : sh_ff == ($past(word) << (5'd31 - $past(dw))));
  endproperty
  a_load_align: assert property (p_load_align) else $error("word not aligned for shift direction");
  property p_word_len;
    load ##1 (shift_en && !load) [*8] |-> left_ff == 6'h00 || left_ff == $past(left_ff, 7) - 6'h0E;
  endproperty
  a_word_len: assert property (p_word_len) else $error("engine not shifting two bits per clock");
endmodule

// ### design/crcg_top.sv
/*
  CRC generator control: control and status registers, input FIFO, start/stop sequencing and
  interrupt. Assumes a same-clock register master and a same-clock idle level from the system.
*/
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module crcg_top
  import crcg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // System
  input wire logic idle_mode,
  output logic crc_irq
);
  // ************************************************************
  // Registers and decode
  // ************************************************************
  logic en_ff;
  logic sidl_ff;
  logic isel_ff;
  logic go_ff;
  logic lsb_ff;
  logic [4:0] dw_ff;
  logic [4:0] polynomial_length_ff;
  logic [31:0] poly_ff;
  logic [15:0] datl_ff;
  logic [15:0] dath_ff;
  logic [31:0] fifo_ff [16];
  logic [3:0] wp_ff;
  logic [3:0] rp_ff;
  logic [4:0] cnt_ff;
  logic ist_ff;
  logic imask_ff;
  logic irq_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [31:0] crc_res;
  logic eng_idle;
  logic wr_ctl1;
  logic wr_datl;
  logic wr_dath;
  logic halt;
  logic run;
  logic [4:0] depth;
  logic full;
  logic push;
  logic pop;
  logic done;
  logic empty_evt;
  logic evt;
  logic [31:0] push_word;

  // Write strobes per register
  assign wr_ctl1 = reg_wr && reg_addr == A_CTL1;
  assign wr_datl = reg_wr && reg_addr == A_DATL;
  assign wr_dath = reg_wr && reg_addr == A_DATH;

  // Sequencing terms
  assign halt = sidl_ff && idle_mode;
  assign run = en_ff && go_ff && !halt;
  assign depth = crcg_depth(dw_ff);
  assign full = cnt_ff >= depth;
  // A word counts once its top half-word register, as set by the data width, is written
  assign push = en_ff && !full && (dw_ff < DW_WIDE_MIN ? wr_datl : wr_dath);
  assign push_word = dw_ff < DW_WIDE_MIN ? {dath_ff, reg_wdata} : {reg_wdata, datl_ff};
  assign pop = run && eng_idle && cnt_ff != 5'h00;
  assign done = run && eng_idle && cnt_ff == 5'h00 && !wr_ctl1;
  assign empty_evt = pop && cnt_ff == 5'h01 && !push;
  assign evt = isel_ff ? empty_evt : done;

  // ************************************************************
  // Control registers
  // ************************************************************
  // Control register one fields; start is self clearing
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      en_ff <= 1'b0;
      sidl_ff <= 1'b0;
      isel_ff <= 1'b0;
      go_ff <= 1'b0;
      lsb_ff <= 1'b0;
    end
    else if (wr_ctl1)
    begin
      en_ff <= reg_wdata[B_EN];
      sidl_ff <= reg_wdata[B_SIDL];
      isel_ff <= reg_wdata[B_ISEL];
      go_ff <= reg_wdata[B_GO];
      lsb_ff <= reg_wdata[B_LSB];
    end
    else if (done)
      go_ff <= 1'b0;
  end

  // Width, length and polynomial; x0 is not stored
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dw_ff <= 5'h00;
      polynomial_length_ff <= 5'h00;
      poly_ff <= RST_WORD;
    end
    else if (reg_wr)
    begin
      if (reg_addr == A_CTL2)
      begin
        dw_ff <= reg_wdata[B_DW +: 5];
        polynomial_length_ff <= reg_wdata[B_POLYNOMIAL_LENGTH +: 5];
      end
      if (reg_addr == A_XORL)
        poly_ff[15:0] <= {reg_wdata[15:1], 1'b0};
      if (reg_addr == A_XORH)
        poly_ff[31:16] <= reg_wdata;
    end
  end

  // Data holding registers, cleared while disabled
  always_ff @(posedge mclk)
  begin
    if (rst || !en_ff)
    begin
      datl_ff <= RST_REG;
      dath_ff <= RST_REG;
    end
    else
    begin
      if (wr_datl)
        datl_ff <= reg_wdata;
      if (wr_dath)
        dath_ff <= reg_wdata;
    end
  end

  // ************************************************************
  // Input FIFO
  // ************************************************************
  // Pointers and valid word count
  always_ff @(posedge mclk)
  begin
    if (rst || !en_ff)
    begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
      cnt_ff <= 5'h00;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff + 4'h1) & (depth[3:0] - 4'h1);
      if (pop)
        rp_ff <= (rp_ff + 4'h1) & (depth[3:0] - 4'h1);
      cnt_ff <= cnt_ff + {4'h0, push} - {4'h0, pop};
    end
  end

  // Word storage
  always_ff @(posedge mclk)
  begin
    if (push)
      fifo_ff[wp_ff] <= push_word;
  end

  // Shift engine
  crcg_engine u_eng (
    .mclk(mclk),
    .rst(rst),
    .clr(!en_ff),
    .load(pop),
    .word(fifo_ff[rp_ff]),
    .shift_en(run),
    .dw(dw_ff),
    .lsb(lsb_ff),
    .poly(poly_ff),
    .polynomial_length(polynomial_length_ff),
    .res_wr_lo(reg_wr && reg_addr == A_RESL),
    .res_wr_hi(reg_wr && reg_addr == A_RESH),
    .res_wdata(reg_wdata),
    .idle(eng_idle),
    .crc(crc_res)
  );

  // ************************************************************
  // Interrupt and read back
  // ************************************************************
  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ist_ff <= 1'b0;
      imask_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      ist_ff <= evt || (ist_ff && !(reg_wr && reg_addr == A_ISTAT && reg_wdata[0]));
      if (reg_wr && reg_addr == A_IMASK)
        imask_ff <= reg_wdata[0];
      irq_ff <= ist_ff && imask_ff;
    end
  end

  // Read data for the addressed register, zero when no read
  always_comb
  begin
    nxt_rdata = RST_REG;
    if (reg_rd)
    begin
      unique case (reg_addr)
        A_CTL1:
        begin
          nxt_rdata[B_EN] = en_ff;
          nxt_rdata[B_SIDL] = sidl_ff;
          nxt_rdata[B_CNT +: 5] = cnt_ff;
          nxt_rdata[B_FULL] = full;
          nxt_rdata[B_EMPTY] = cnt_ff == 5'h00;
          nxt_rdata[B_ISEL] = isel_ff;
          nxt_rdata[B_GO] = go_ff;
          nxt_rdata[B_LSB] = lsb_ff;
        end
        A_CTL2: nxt_rdata = {3'b000, dw_ff, 3'b000, polynomial_length_ff};
        A_XORL: nxt_rdata = poly_ff[15:0];
        A_XORH: nxt_rdata = poly_ff[31:16];
        A_DATL: nxt_rdata = datl_ff;
        A_DATH: nxt_rdata = dath_ff;
        A_RESL: nxt_rdata = crc_res[15:0];
        A_RESH: nxt_rdata = crc_res[31:16];
        A_ISTAT: nxt_rdata = {15'h0000, ist_ff};
        A_IMASK: nxt_rdata = {15'h0000, imask_ff};
        default: nxt_rdata = RST_REG;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_ff <= RST_REG;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;
  assign crc_irq = irq_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_idle_halt;
    sidl_ff && idle_mode |-> !pop && !done;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("activity while stopped in idle");
  property p_empty_irq;
    isel_ff && pop && cnt_ff == 5'h01 && !push |=> ist_ff && cnt_ff == 5'h00;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("no event on last word taken");
  property p_done_irq;
    !isel_ff && go_ff && en_ff && !halt && eng_idle && cnt_ff == 5'h00 && !wr_ctl1 |=> !go_ff && ist_ff;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion did not clear start and flag");
  property p_cnt_max;
    $stable(dw_ff) [*2] |-> cnt_ff <= depth;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("valid word count above depth");
  property p_disable;
    !en_ff |=> cnt_ff == 5'h00 && wp_ff == 4'h0 && datl_ff == RST_REG;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not empty the FIFO");
  property p_manual_stop;
    wr_ctl1 && !reg_wdata[B_GO] && !reg_wdata[B_ISEL] && !isel_ff && !ist_ff |=> !ist_ff;
  endproperty
  a_manual_stop: assert property (p_manual_stop) else $error("software stop raised an event");
  property p_full_refuse;
    full && !pop |=> $stable(cnt_ff) || !$past(en_ff);
  endproperty
  a_full_refuse: assert property (p_full_refuse) else $error("word accepted while full");
  property p_read_lat;
    reg_rd && reg_addr == A_CTL1 |=> reg_rdata[B_CNT +: 5] == $past(cnt_ff) ##1 ($past(reg_rd) || reg_rdata == RST_REG);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("count read back wrong");
  c_empty_evt: cover property (isel_ff && empty_evt);
  c_done_evt: cover property (!isel_ff && done);
  c_full: cover property (full && en_ff);
  c_idle_halt: cover property (halt && go_ff && cnt_ff != 5'h00);
endmodule

// ### tb/crcg_top_tb_top.sv
/*
  Self-checking bench for the CRC generator control block: register port, FIFO count and flags,
  shifting, interrupt source select, stop in idle. Assumes the register map of crcg_pkg.
*/
`timescale 1ns/100ps
module crcg_top_tb_top
  import crcg_pkg::*;
;
  // ****************************
  // Signals and instance
  // ****************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic idle_mode = 1'b0;
  logic crc_irq;
  logic [15:0] rv;
  int errors = 0;
  int checked = 0;

  crcg_top i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode), .crc_irq(crc_irq));

  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  // ****************************
  // Helpers
  // ****************************
  task automatic test_done();
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Bounded poll of one register bit
  task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
    for (int n = 0; n < 60; n++)
    begin
      rd(a, rv);
      if (rv[b] === v)
        return;
    end
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask

  function automatic logic [15:0] ctl(input int en, sidl, cnt, full, empty, isel, go, lsb);
    return {1'(en), 1'b0, 1'(sidl), 5'(cnt), 1'(full), 1'(empty), 1'(isel), 1'(go), 1'(lsb), 3'b000};
  endfunction

  // Plain LFSR reference, result not reflected
  function automatic logic [31:0] crc_ref(input logic [31:0] init, data, poly, input int n, dwb,
    input logic lsb);
    logic [31:0] c;
    logic [31:0] m;
    logic fb;
    m = (n == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
    c = init & m;
    for (int i = 0; i < dwb; i++)
    begin
      fb = c[n-1] ^ (lsb ? data[i] : data[dwb-1-i]);
      c = (c << 1) & m;
      if (fb)
        c = c ^ ((poly | 32'h0000_0001) & m);
    end
    return c;
  endfunction

  task automatic push(input logic [31:0] w, input logic wide);
    wr(A_DATL, w[15:0]);
    if (wide)
      wr(A_DATH, w[31:16]);
  endtask

  // Enable with 16-bit words and a 16-bit polynomial, irq unmasked
  task automatic setup();
    wr(A_CTL1, 16'h8000);
    wr(A_CTL2, 16'h0F0F);
    wr(A_IMASK, 16'h0001);
  endtask

  task automatic teardown();
    wr(A_CTL1, 16'h0000);
    wr(A_ISTAT, 16'h0001);
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_regs();
    rd(A_CTL1, rv);
    chk(rv, 16'h0040);
    chk({15'h0000, crc_irq}, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, rv);
    chk(rv, 16'h0000);
    wr(A_CTL2, 16'hFFFF);
    rd(A_CTL2, rv);
    chk(rv, 16'h1F1F);
    wr(A_XORL, 16'hFFFF);
    rd(A_XORL, rv);
    chk(rv, 16'hFFFE);
  endtask

  task automatic t_fifo();
    int dws[3] = '{31, 15, 7};
    int dep[3] = '{4, 8, 16};
    for (int k = 0; k < 3; k++)
    begin
      wr(A_CTL1, 16'h8000);
      wr(A_CTL2, {3'b000, 5'(dws[k]), 8'h0F});
      for (int i = 0; i < dep[k] - 1; i++)
        push(32'h0000_00A5 + i, dws[k] >= 16);
      rd(A_CTL1, rv);
      chk(rv, ctl(1, 0, 5'(dep[k] - 1), 0, 0, 0, 0, 0));
      push(32'h0000_0011, dws[k] >= 16);
      push(32'h0000_0022, dws[k] >= 16);
      rd(A_CTL1, rv);
      chk(rv, ctl(1, 0, 5'(dep[k]), 1, 0, 0, 0, 0));
      wr(A_CTL1, 16'h0000);
      rd(A_CTL1, rv);
      chk(rv, ctl(0, 0, 0, 0, 1, 0, 0, 0));
    end
  endtask

  task automatic t_crc(input logic lsb);
    setup();
    wr(A_XORL, 16'h1021);
    wr(A_XORH, 16'h0000);
    wr(A_RESL, 16'hFFFF);
    idle_mode <= 1'b1;
    push(32'h0000_1234, 1'b0);
    wr(A_CTL1, ctl(1, 0, 0, 0, 0, 0, 1, lsb));
    wait_bit(A_CTL1, B_GO, 1'b0);
    rd(A_ISTAT, rv);
    chk(rv, 16'h0001);
    rd(A_RESL, rv);
    chk(rv, 16'(crc_ref(32'h0000_FFFF, 32'h0000_1234, 32'h0000_1021, 16, 16, lsb)));
    chk({15'h0000, crc_irq}, 16'h0001);
    wr(A_IMASK, 16'h0000);
    // Interrupt output follows the mask one clock later
    @(posedge mclk);
    #1;
    chk({15'h0000, crc_irq}, 16'h0000);
    wr(A_IMASK, 16'h0001);
    wr(A_ISTAT, 16'h0001);
    rd(A_ISTAT, rv);
    chk(rv, 16'h0000);
    chk({15'h0000, crc_irq}, 16'h0000);
    @(posedge mclk);
    idle_mode <= 1'b0;
    teardown();
    // Disable clears the result and data holding registers
    rd(A_RESL, rv);
    chk(rv, 16'h0000);
    rd(A_DATL, rv);
    chk(rv, 16'h0000);
  endtask

  task automatic t_isel();
    setup();
    push(32'h0000_BEEF, 1'b0);
    wr(A_CTL1, ctl(1, 0, 0, 0, 0, 1, 1, 0));
    wait_bit(A_ISTAT, 0, 1'b1);
    rd(A_CTL1, rv);
    chk(rv, ctl(1, 0, 0, 0, 1, 1, 1, 0));
    wait_bit(A_CTL1, B_GO, 1'b0);
    teardown();
  endtask

  task automatic t_manual();
    setup();
    for (int i = 0; i < 4; i++)
      push(32'h0000_0101 * i, 1'b0);
    wr(A_CTL1, ctl(1, 0, 0, 0, 0, 0, 1, 0));
    wr(A_CTL1, 16'h8000);
    repeat (80) @(posedge mclk);
    rd(A_ISTAT, rv);
    chk(rv, 16'h0000);
    chk({15'h0000, crc_irq}, 16'h0000);
    teardown();
  endtask

  task automatic t_idle();
    setup();
    wr(A_CTL1, ctl(1, 1, 0, 0, 0, 0, 0, 0));
    idle_mode <= 1'b1;
    push(32'h0000_5A5A, 1'b0);
    wr(A_CTL1, ctl(1, 1, 0, 0, 0, 0, 1, 0));
    repeat (40) @(posedge mclk);
    rd(A_CTL1, rv);
    chk(rv, ctl(1, 1, 1, 0, 0, 0, 1, 0));
    @(posedge mclk);
    idle_mode <= 1'b0;
    wait_bit(A_CTL1, B_GO, 1'b0);
    rd(A_ISTAT, rv);
    chk(rv, 16'h0001);
    teardown();
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_fifo();
    t_crc(1'b0);
    t_crc(1'b1);
    t_isel();
    t_manual();
    t_idle();
    test_done();
  end
endmodule
